// ### rtl/system_bus_tenure_arbitration.sv
// Address and data tenure handshakes for the multi-master system bus.
// Assumes pins are resolved by the pad ring from level/enable pairs; straps are static.
//
// What this block does
// [R1] External arbiter: drive bus request when wanting bus
// [R2] Internal arbiter: external master requests on request pin
// [R3] Internal arbiter: drive grant to external master
// [R4] External arbiter: grant pin input grants us bus
// [R5] Hold address busy, negate briefly, then release
// [R6] Never take address bus while others busy
// [R7] Pulse transfer start for internal tenures
// [R8] Respond to external transfer start: snoop, serve
// [R9] Address acknowledge ends the address tenure
// [R10] Retry on address retry; assert retry on snoop hit with snooping enabled
// [R11] Internal arbiter: drive data grant to external
// [R12] External arbiter: data grant input grants us
// [R13] Hold data busy, negate briefly, then release
// [R14] Never take data bus while others busy
// [R15] Master drives write data; slave drives read
// [R16] Host port selects 64-bit or 32-bit data bus
// [R17] Pin directions fixed from strap at reset
`timescale 1ns/1ps

module system_bus_tenure_arbitration #(
  parameter int unsigned DATA_W = bus_tenure_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire bus_tenure_pkg::bus_pins_type pinIn,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic extArbStrap,
  input wire logic hostPortStrap,
  input wire bus_tenure_pkg::txn_req_type txnReq,
  input wire logic snoopEnable,
  input wire logic snoopHit,
  output bus_tenure_pkg::bus_pins_type pinOut,
  output bus_tenure_pkg::bus_pins_type pinOe,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic [DATA_W-1:0] rdData,
  output logic txnDone,
  output logic snoopStrobe,
  output logic busWide
);

  // Asserted level of an active-low line
  function automatic logic isOn(input logic pinLevel);
    isOn = (pinLevel == bus_tenure_pkg::PIN_ASSERTED);
  endfunction : isOn

  // Synchroniser stages; stage one feeds stage two only
  bus_tenure_pkg::bus_pins_type pinSync1_q, pinSync2_q;
  logic [DATA_W-1:0] dataSync1_q, dataSync2_q;
  logic [1:0] strapSync1_q, strapSync2_q; // [1] ext arbiter, [0] host port

  // Two flops on every pin input before any logic looks at it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync1_q <= '1;
      pinSync2_q <= '1;
      dataSync1_q <= '0;
      dataSync2_q <= '0;
      strapSync1_q <= 2'h0;
      strapSync2_q <= 2'h0;
    end else begin
      pinSync1_q <= pinIn;
      pinSync2_q <= pinSync1_q;
      dataSync1_q <= dataIn;
      dataSync2_q <= dataSync1_q;
      strapSync1_q <= {extArbStrap, hostPortStrap};
      strapSync2_q <= strapSync1_q;
    end
  end

  // Configuration captured once after reset release
  logic extMode_q, extMode_d; // External arbiter in use
  logic hostEn_q, hostEn_d; // Host port enabled (32-bit data bus)
  logic strapDone_q, strapDone_d;
  logic [bus_tenure_pkg::STRAP_CNT_W-1:0] strapCnt_q, strapCnt_d;

  // Strap capture: direction never changes afterwards, so no pin flips mid-run
  always_comb begin
    extMode_d = extMode_q;
    hostEn_d = hostEn_q;
    strapDone_d = strapDone_q;
    strapCnt_d = strapCnt_q;
    if (!strapDone_q) begin
      if (strapCnt_q == bus_tenure_pkg::STRAP_CNT_W'(bus_tenure_pkg::STRAP_SETTLE_CYCLES - 1)) begin
        extMode_d = strapSync2_q[1]; // R17
        hostEn_d = strapSync2_q[0]; // R16
        strapDone_d = 1'b1;
      end else begin
        strapCnt_d = strapCnt_q + 1'b1;
      end
    end
  end

  // Strap registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extMode_q <= 1'b0;
      hostEn_q <= 1'b0;
      strapDone_q <= 1'b0;
      strapCnt_q <= '0;
    end else begin
      extMode_q <= extMode_d;
      hostEn_q <= hostEn_d;
      strapDone_q <= strapDone_d;
      strapCnt_q <= strapCnt_d;
    end
  end

  // Control state
  bus_tenure_pkg::tenure_state_type state_q, state_d;
  logic abbRel_q, abbRel_d; // Address busy in its brief negation
  logic dbbRel_q, dbbRel_d; // Data busy in its brief negation
  logic extGrant_q, extGrant_d; // Address bus granted to an external master
  logic extTenure_q, extTenure_d; // External address tenure in progress
  logic retryOwn_q, retryOwn_d; // We are asking the external master to retry
  logic extDataPend_q, extDataPend_d; // Data bus granted to an external master
  bus_tenure_pkg::bus_pins_type pinOut_q, pinOut_d, pinOe_q, pinOe_d;
  logic [DATA_W-1:0] dataOut_q, dataOut_d, rdData_q, rdData_d;
  logic dataOe_q, dataOe_d, txnDone_q, txnDone_d, snoop_q, snoop_d;
  logic busWide_q, busWide_d;
  bus_tenure_pkg::bus_pins_type ownOe1_q, ownOe2_q; // Own enables, delayed like the pins

  // Own enables pass the same two stages as the pins, so what we drove
  // comes back through the synchroniser lined up with its own mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ownOe1_q <= '0;
      ownOe2_q <= '0;
    end else begin
      ownOe1_q <= pinOe_q;
      ownOe2_q <= ownOe1_q;
    end
  end

  // Busy from someone else: ignore lines while we drive them ourselves
  logic extAbbBusy, extDbbBusy, extTsSeen;
  assign extAbbBusy = isOn(pinSync2_q.abbN) && !pinOe_q.abbN && !abbRel_q && !ownOe2_q.abbN;
  assign extDbbBusy = isOn(pinSync2_q.dbbN) && !pinOe_q.dbbN && !dbbRel_q && !ownOe2_q.dbbN;
  // Without the delayed mask our own start pulse would be snooped as foreign
  assign extTsSeen = isOn(pinSync2_q.tsN) && !pinOe_q.tsN && !ownOe2_q.tsN && !extTenure_q;

  // Next-state and pin drive; pin levels follow the next state so they align with it
  always_comb begin
    state_d = state_q;
    abbRel_d = 1'b0;
    dbbRel_d = 1'b0;
    extGrant_d = extGrant_q;
    extTenure_d = extTenure_q;
    retryOwn_d = retryOwn_q;
    extDataPend_d = extDataPend_q;
    dataOut_d = dataOut_q;
    rdData_d = rdData_q;
    txnDone_d = 1'b0;
    snoop_d = 1'b0;
    busWide_d = !hostEn_d; // R16
    case (state_q)
      bus_tenure_pkg::ST_IDLE: begin
        if (txnReq.valid && strapDone_q && !extGrant_q) begin
          state_d = bus_tenure_pkg::ST_ARB;
          dataOut_d = txnReq.data;
        end
      end
      bus_tenure_pkg::ST_ARB: begin
        // External grant or self grant, and nobody else on the address bus
        if (!extAbbBusy && (extMode_q ? isOn(pinSync2_q.bgN) : !extGrant_q)) begin // R4 R6
          state_d = bus_tenure_pkg::ST_START;
        end
      end
      bus_tenure_pkg::ST_START: begin
        state_d = bus_tenure_pkg::ST_ATEN;
      end
      bus_tenure_pkg::ST_ATEN: begin
        if (isOn(pinSync2_q.aackN)) begin // R9
          abbRel_d = 1'b1; // R5
          // Retry reruns the whole tenure from arbitration
          state_d = isOn(pinSync2_q.artryN) ? bus_tenure_pkg::ST_ARB
                                             : bus_tenure_pkg::ST_DARB; // R10
        end
      end
      bus_tenure_pkg::ST_DARB: begin
        if (!extDbbBusy && (extMode_q ? isOn(pinSync2_q.dbgN) : !extDataPend_q)) begin // R12 R14
          state_d = bus_tenure_pkg::ST_DTEN;
        end
      end
      bus_tenure_pkg::ST_DTEN: begin
        if (isOn(pinSync2_q.taN)) begin
          dbbRel_d = 1'b1; // R13
          rdData_d = dataSync2_q; // R15
          txnDone_d = 1'b1;
          state_d = bus_tenure_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = bus_tenure_pkg::ST_IDLE;
      end
    endcase

    // On-chip arbiter serving external masters
    if (!extMode_q && strapDone_q) begin
      if (!extGrant_q && isOn(pinSync2_q.brN) && state_q == bus_tenure_pkg::ST_IDLE
          && !txnReq.valid && !extAbbBusy && !extTenure_q) begin
        extGrant_d = 1'b1; // R2 R3
      end
    end
    // External tenure detection works in both modes
    if (extTsSeen) begin
      extGrant_d = 1'b0;
      extTenure_d = 1'b1;
      snoop_d = 1'b1; // R8
      retryOwn_d = snoopEnable && snoopHit; // R10
    end else if (extTenure_q && isOn(pinSync2_q.aackN)) begin
      extTenure_d = 1'b0;
      retryOwn_d = 1'b0;
      extDataPend_d = !extMode_q && !isOn(pinSync2_q.artryN); // R11
    end
    if (extDataPend_q && isOn(pinSync2_q.taN)) begin
      extDataPend_d = 1'b0;
    end

    // Pin drive from the next state
    pinOut_d = '1;
    pinOe_d = '0;
    if (extMode_d && state_d == bus_tenure_pkg::ST_ARB) begin
      pinOut_d.brN = bus_tenure_pkg::PIN_ASSERTED; // R1
    end
    pinOe_d.brN = extMode_d && strapDone_d; // R17
    pinOut_d.bgN = !extGrant_d; // R3
    pinOe_d.bgN = !extMode_d && strapDone_d; // R17
    pinOut_d.dbgN = !extDataPend_d; // R11
    pinOe_d.dbgN = !extMode_d && strapDone_d; // R17
    if (state_d == bus_tenure_pkg::ST_START) begin
      pinOut_d.tsN = bus_tenure_pkg::PIN_ASSERTED; // R7
      pinOe_d.tsN = 1'b1;
    end
    if (state_d == bus_tenure_pkg::ST_START || state_d == bus_tenure_pkg::ST_ATEN) begin
      pinOut_d.abbN = bus_tenure_pkg::PIN_ASSERTED; // R5
      pinOe_d.abbN = 1'b1;
    end else if (abbRel_d) begin
      pinOe_d.abbN = 1'b1; // R5
    end
    if (retryOwn_d) begin
      pinOut_d.artryN = bus_tenure_pkg::PIN_ASSERTED; // R10
      pinOe_d.artryN = 1'b1;
    end
    if (state_d == bus_tenure_pkg::ST_DTEN) begin
      pinOut_d.dbbN = bus_tenure_pkg::PIN_ASSERTED; // R13
      pinOe_d.dbbN = 1'b1;
    end else if (dbbRel_d) begin
      pinOe_d.dbbN = 1'b1; // R13
    end
    dataOe_d = (state_d == bus_tenure_pkg::ST_DTEN) && txnReq.write; // R15
  end

  // Control registers; every output comes straight from here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= bus_tenure_pkg::ST_IDLE;
      abbRel_q <= 1'b0;
      dbbRel_q <= 1'b0;
      extGrant_q <= 1'b0;
      extTenure_q <= 1'b0;
      retryOwn_q <= 1'b0;
      extDataPend_q <= 1'b0;
      pinOut_q <= '1;
      pinOe_q <= '0;
      dataOut_q <= '0;
      dataOe_q <= 1'b0;
      rdData_q <= '0;
      txnDone_q <= 1'b0;
      snoop_q <= 1'b0;
      busWide_q <= 1'b0;
    end else begin
      state_q <= state_d;
      abbRel_q <= abbRel_d;
      dbbRel_q <= dbbRel_d;
      extGrant_q <= extGrant_d;
      extTenure_q <= extTenure_d;
      retryOwn_q <= retryOwn_d;
      extDataPend_q <= extDataPend_d;
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
      dataOut_q <= dataOut_d;
      dataOe_q <= dataOe_d;
      rdData_q <= rdData_d;
      txnDone_q <= txnDone_d;
      snoop_q <= snoop_d;
      busWide_q <= busWide_d;
    end
  end

  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign dataOut = dataOut_q;
  assign dataOe = dataOe_q;
  assign rdData = rdData_q;
  assign txnDone = txnDone_q;
  assign snoopStrobe = snoop_q;
  assign busWide = busWide_q;

  // Checks on what this block drives
  AST_BR_DRIVE: assert property (@(posedge clk) disable iff (rst) // R1
    (state_q == bus_tenure_pkg::ST_ARB && extMode_q) |-> (!pinOut_q.brN && pinOe_q.brN))
    else $error("bus request not asserted while arbitrating");
  AST_BG_GRANT: assert property (@(posedge clk) disable iff (rst) // R3
    extGrant_q |-> (!pinOut_q.bgN && pinOe_q.bgN && !extMode_q))
    else $error("grant not driven to external master");
  AST_ABB_RELEASE: assert property (@(posedge clk) disable iff (rst) // R5
    (state_q == bus_tenure_pkg::ST_ATEN ##1 state_q != bus_tenure_pkg::ST_ATEN)
    |-> (pinOe_q.abbN && pinOut_q.abbN) ##1 !pinOe_q.abbN)
    else $error("address busy not negated then released");
  AST_ABB_WAIT: assert property (@(posedge clk) disable iff (rst) // R6
    (state_q == bus_tenure_pkg::ST_ARB && extAbbBusy) |=> state_q != bus_tenure_pkg::ST_START)
    else $error("address bus taken while busy");
  AST_TS_PULSE: assert property (@(posedge clk) disable iff (rst) // R7
    $rose(state_q == bus_tenure_pkg::ST_START) |-> (!pinOut_q.tsN && pinOe_q.tsN)
    ##1 (pinOut_q.tsN || !pinOe_q.tsN))
    else $error("transfer start not a single pulse");
  AST_SNOOP: assert property (@(posedge clk) disable iff (rst) // R8
    extTsSeen |=> snoop_q)
    else $error("external tenure not answered");
  AST_ADDRESS_ACKNOWLEDGE_END: assert property (@(posedge clk) disable iff (rst) // R9
    (state_q == bus_tenure_pkg::ST_ATEN && isOn(pinSync2_q.aackN))
    |=> state_q != bus_tenure_pkg::ST_ATEN)
    else $error("address tenure outlived acknowledge");
  AST_RETRY: assert property (@(posedge clk) disable iff (rst) // R10
    (state_q == bus_tenure_pkg::ST_ATEN && isOn(pinSync2_q.aackN) && isOn(pinSync2_q.artryN))
    |=> state_q == bus_tenure_pkg::ST_ARB)
    else $error("retry did not restart arbitration");
  AST_DBG_GRANT: assert property (@(posedge clk) disable iff (rst) // R11
    extDataPend_q |-> (!pinOut_q.dbgN && pinOe_q.dbgN))
    else $error("data grant not driven");
  AST_DBB_RELEASE: assert property (@(posedge clk) disable iff (rst) // R13
    (state_q == bus_tenure_pkg::ST_DTEN ##1 state_q == bus_tenure_pkg::ST_IDLE)
    |-> (pinOe_q.dbbN && pinOut_q.dbbN && txnDone_q) ##1 !pinOe_q.dbbN)
    else $error("data busy not negated then released");
  AST_DBB_WAIT: assert property (@(posedge clk) disable iff (rst) // R14
    (state_q == bus_tenure_pkg::ST_DARB && extDbbBusy) |=> state_q != bus_tenure_pkg::ST_DTEN)
    else $error("data bus taken while busy");
  AST_WR_DATA: assert property (@(posedge clk) disable iff (rst) // R15
    dataOe_q |-> (state_q == bus_tenure_pkg::ST_DTEN && $stable(dataOut_q)))
    else $error("write data driven outside data tenure");
  AST_WIDTH: assert property (@(posedge clk) disable iff (rst) // R16
    strapDone_q |=> busWide_q == !hostEn_q)
    else $error("bus width does not follow host port");
  AST_DIR_FIXED: assert property (@(posedge clk) disable iff (rst) // R17
    strapDone_q |=> ($stable(extMode_q) && (extMode_q ? !pinOe_q.bgN : !pinOe_q.brN)))
    else $error("pin direction changed or wrong");

endmodule : system_bus_tenure_arbitration

// ### rtl/bus_tenure_pkg.sv
// Shared constants and carrier types for the system bus tenure arbiter.
// Assumes all bus handshake pins are active low and resolved outside (open drain/tristate).
package bus_tenure_pkg;

  // Pin polarity: handshake lines are asserted when low
  localparam logic PIN_ASSERTED = 1'b0;
  localparam logic PIN_NEGATED = 1'b1;

  // Reset values of driven pin levels and enables
  localparam logic PIN_LEVEL_RST = 1'b1;
  localparam logic PIN_EN_RST = 1'b0;

  // Strap capture waits for the two synchroniser stages to fill
  localparam int unsigned STRAP_SETTLE_CYCLES = 3;
  localparam int unsigned STRAP_CNT_W = 2;

  // Clock period, and the short negation before release (one full clock period, so one cycle)
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned NEGATE_TIME_PS = 5000;
  localparam int unsigned NEGATE_CYCLES =
    (NEGATE_TIME_PS / CLK_PERIOD_PS) < 1 ? 1 : (NEGATE_TIME_PS / CLK_PERIOD_PS);

  // Default width of the most significant data word
  localparam int unsigned DATA_W = 32;

  // Handshake pin bundle, one bit per line, active low on the wire
  typedef struct packed {
    logic brN;
    logic bgN;
    logic abbN;
    logic tsN;
    logic aackN;
    logic artryN;
    logic dbgN;
    logic dbbN;
    logic taN;
  } bus_pins_type;

  // Request from an internal master (core or DMA)
  typedef struct packed {
    logic valid;
    logic write;
    logic [DATA_W-1:0] data;
  } txn_req_type;

  // Tenure state machine, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ARB = 6'h02,
    ST_START = 6'h04,
    ST_ATEN = 6'h08,
    ST_DARB = 6'h10,
    ST_DTEN = 6'h20
  } tenure_state_type;

endpackage : bus_tenure_pkg

// ### tb/bus_partner_model.sv
// Behavioural far side: external arbiter plus one slave on the tenure handshake lines.
// Assumes every handshake line is open drain with a pull-up, resolved here.
`timescale 1ns/1ps

module bus_partner_model #(
  parameter logic [31:0] RD_WORD = 32'h5A3C_96E1
) (
  input wire logic clk,
  input wire logic rst,
  input wire bus_tenure_pkg::bus_pins_type devOut,
  input wire bus_tenure_pkg::bus_pins_type devOe,
  input wire bus_tenure_pkg::bus_pins_type tbDrive,
  input wire logic [31:0] devData,
  input wire logic devDataOe,
  input wire logic extMode,
  input wire logic retryOnce,
  output bus_tenure_pkg::bus_pins_type wireLvl,
  output logic [31:0] dataWire,
  output logic [31:0] wrSeen
);
  logic [8:0] own; // Lines this model pulls low
  logic [2:0] aCnt; // Address acknowledge sequencer, held 5 cycles
  logic [2:0] dCnt; // Transfer acknowledge sequencer, held 5 cycles
  logic dPend; // Data grant owed after a clean acknowledge
  logic retryUsed; // Only the first acknowledge carries a retry
  logic bgQ; // Registered grant, arbiter reacts one cycle late
  logic [31:0] idleData; // Flips every cycle so stale data never looks valid

  // Pull-ups: a line is low only while somebody drives it low
  assign wireLvl = (~devOe | devOut) & own & tbDrive;
  assign own = {1'b1, ~(extMode & bgQ), 2'b11, ~(aCnt >= 3'h3),
    ~(retryOnce & ~retryUsed & (aCnt >= 3'h3)), ~(extMode & dPend), 1'b1,
    ~(dCnt >= 3'h3)};
  assign dataWire = devDataOe ? devData : ((dCnt >= 3'h3) ? RD_WORD : idleData);

  // Arbiter and slave sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aCnt <= 3'h0;
      dCnt <= 3'h0;
      dPend <= 1'b0;
      retryUsed <= 1'b0;
      bgQ <= 1'b0;
      idleData <= 32'h0;
      wrSeen <= 32'h0;
    end else begin
      bgQ <= ~wireLvl.brN;
      idleData <= ~dataWire;
      if (aCnt != 3'h0 || !wireLvl.tsN) begin
        aCnt <= aCnt + 3'h1;
      end
      if (aCnt == 3'h7) begin
        retryUsed <= retryUsed | retryOnce;
        dPend <= extMode & ~(retryOnce & ~retryUsed);
      end
      // In arbiter mode the slave only serves the device's own data tenure
      if (dCnt != 3'h0 || (!wireLvl.dbbN && (devOe.dbbN || !extMode))) begin
        dCnt <= dCnt + 3'h1;
      end
      if (dCnt == 3'h4) begin
        wrSeen <= dataWire;
      end
      if (dCnt == 3'h7) begin
        dPend <= 1'b0;
      end
    end
  end
endmodule : bus_partner_model

// ### tb/testbench.sv
// Self-checking bench for the tenure arbiter against the behavioural far side.
// Assumes the partner model resolves all handshake lines with pull-ups.
`timescale 1ns/1ps

module testbench;
  localparam logic [31:0] RD_WORD = 32'h5A3C_96E1;
  logic clk, rst, extArbStrap, hostPortStrap, snoopEnable, snoopHit, retryOnce;
  bus_tenure_pkg::bus_pins_type tbDrive; // Lines the bench pulls low as a foreign master
  bus_tenure_pkg::bus_pins_type pinOut, pinOe, wireLvl;
  bus_tenure_pkg::txn_req_type txnReq;
  logic [31:0] dataOut, rdData, dataWire, wrSeen;
  logic dataOe, txnDone, snoopStrobe, busWide;
  int badCount, checksDone, cycles, tsCnt, abbNeg, dbbNeg, dbbLow, brLow, snpCnt;

  system_bus_tenure_arbitration i_dut (.clk(clk), .rst(rst), .pinIn(wireLvl),
    .dataIn(dataWire), .extArbStrap(extArbStrap), .hostPortStrap(hostPortStrap),
    .txnReq(txnReq), .snoopEnable(snoopEnable), .snoopHit(snoopHit), .pinOut(pinOut),
    .pinOe(pinOe), .dataOut(dataOut), .dataOe(dataOe), .rdData(rdData),
    .txnDone(txnDone), .snoopStrobe(snoopStrobe), .busWide(busWide));

  bus_partner_model i_partner (.clk(clk), .rst(rst), .devOut(pinOut), .devOe(pinOe),
    .tbDrive(tbDrive), .devData(dataOut), .devDataOe(dataOe), .extMode(extArbStrap),
    .retryOnce(retryOnce), .wireLvl(wireLvl), .dataWire(dataWire), .wrSeen(wrSeen));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts what the device drives; also cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (pinOe.tsN && !pinOut.tsN) tsCnt++;
    if (pinOe.abbN && pinOut.abbN) abbNeg++;
    if (pinOe.dbbN && pinOut.dbbN) dbbNeg++;
    if (pinOe.dbbN && !pinOut.dbbN) dbbLow++;
    if (pinOe.brN && !pinOut.brN) brLow++;
    if (snoopStrobe) snpCnt++;
    if (cycles == 5000) begin
      badCount++;
      giveVerdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Full reset with new straps; drive and snoop counters start fresh, cycles keeps counting
  task automatic do_reset(input logic ext, input logic host);
    rst = 1'b1;
    extArbStrap = ext;
    hostPortStrap = host;
    tick(10);
    rst = 1'b0;
    tick(6);
    tsCnt = 0;
    abbNeg = 0;
    dbbNeg = 0;
    dbbLow = 0;
    brLow = 0;
    snpCnt = 0;
  endtask : do_reset

  // Waits for the completion pulse, then withdraws the request
  task automatic wait_done(input int lim);
    for (int n = 0; n < lim && txnDone !== 1'b1; n++) tick(1);
    check("txnDone", txnDone, 1'b1);
    txnReq = '0;
    tick(4);
  endtask : wait_done

  // Write through an external arbiter while a foreign master holds the data bus
  task automatic test_ext_write();
    do_reset(1'b1, 1'b0);
    check("busWide", busWide, 1'b1);
    check("brOe", pinOe.brN, 1'b1);
    check("bgOe", pinOe.bgN, 1'b0);
    tbDrive.dbbN = 1'b0;
    txnReq = '{1'b1, 1'b1, 32'hA5C3_0F96};
    tick(60);
    check("dbbLow", dbbLow, 0);
    check("brLow", brLow != 0, 1'b1);
    tbDrive.dbbN = 1'b1;
    wait_done(100);
    check("tsCnt", tsCnt, 1);
    check("abbNeg", abbNeg, bus_tenure_pkg::NEGATE_CYCLES);
    check("dbbNeg", dbbNeg, bus_tenure_pkg::NEGATE_CYCLES);
    check("wrSeen", wrSeen, 32'hA5C3_0F96);
    check("snpOwn", snpCnt, 0);
    $display("test ext_write done");
  endtask : test_ext_write

  // Read held off by foreign address busy, then retried once
  task automatic test_ext_read_retry();
    do_reset(1'b1, 1'b1);
    check("busWide", busWide, 1'b0);
    tbDrive.abbN = 1'b0;
    retryOnce = 1'b1;
    txnReq = '{1'b1, 1'b0, 32'h0};
    tick(40);
    check("tsHeld", tsCnt, 0);
    tbDrive.abbN = 1'b1;
    wait_done(300);
    check("tsRetry", tsCnt, 2);
    check("abbNeg", abbNeg, 2 * bus_tenure_pkg::NEGATE_CYCLES);
    check("rdData", rdData, RD_WORD);
    retryOnce = 1'b0;
    $display("test ext_read_retry done");
  endtask : test_ext_read_retry

  // Foreign master tenure under the on-chip arbiter, snoop hit or miss
  task automatic ext_tenure(input logic hit);
    logic rty; // Retry expected only for a hit with snooping on
    rty = hit & snoopEnable;
    snoopHit = hit;
    tbDrive.brN = 1'b0;
    for (int n = 0; n < 20 && pinOut.bgN !== 1'b0; n++) tick(1);
    check("bgOut", pinOut.bgN, 1'b0);
    tbDrive.brN = 1'b1;
    tbDrive.tsN = 1'b0;
    tick(1);
    tbDrive.tsN = 1'b1;
    for (int n = 0; n < 10 && snoopStrobe !== 1'b1; n++) tick(1);
    check("snoop", snoopStrobe, 1'b1);
    check("address_retry", pinOut.artryN || !pinOe.artryN, !rty);
    for (int n = 0; n < 30 && pinOut.dbgN !== 1'b0; n++) tick(1);
    check("dbg", pinOut.dbgN, rty);
    if (!rty) begin
      tbDrive.dbbN = 1'b0;
      for (int n = 0; n < 10 && wireLvl.taN !== 1'b0; n++) tick(1);
      tbDrive.dbbN = 1'b1;
      tick(8);
      check("dbgFree", pinOut.dbgN, 1'b1);
    end
    tick(6);
  endtask : ext_tenure

  task automatic test_int_arbiter();
    do_reset(1'b0, 1'b0);
    check("brOe", pinOe.brN, 1'b0);
    check("grantOe", {pinOe.bgN, pinOe.dbgN}, 2'h3);
    ext_tenure(1'b1);
    ext_tenure(1'b0);
    snoopEnable = 1'b0;
    ext_tenure(1'b1);
    snoopEnable = 1'b1;
    // Own read through the on-chip arbiter
    txnReq = '{1'b1, 1'b0, 32'h0};
    wait_done(100);
    check("tsOwn", tsCnt, 1);
    check("snpOwn", snpCnt, 3);
    check("dbbNegOwn", dbbNeg, bus_tenure_pkg::NEGATE_CYCLES);
    check("dbgOwn", pinOut.dbgN, 1'b1);
    check("rdOwn", rdData, RD_WORD);
    $display("test int_arbiter done");
  endtask : test_int_arbiter

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : giveVerdict

  // Main sequence
  initial begin
    rst = 1'b1;
    extArbStrap = 1'b1;
    hostPortStrap = 1'b0;
    snoopEnable = 1'b1;
    snoopHit = 1'b0;
    retryOnce = 1'b0;
    tbDrive = '1;
    txnReq = '0;
    badCount = 0;
    checksDone = 0;
    cycles = 0;
    test_ext_write();
    test_ext_read_retry();
    test_int_arbiter();
    giveVerdict();
  end
endmodule : testbench
